// ==== design/bum_boot_update_mode_select.sv ====
// Purpose: Latches the strap-selected field update mode and routes four
//          port pins to the chosen serial interface.
// Assumes: Inputs are synchronous to sys_clk; reset covers power-on and
//          chip reset.
// Notes:   Pins are split into input, output and output enable.
`timescale 1ns/1ps

module bum_boot_update_mode_select (
  input  wire logic                sys_clk,
  input  wire logic                reset,
  input  wire logic                ownerPolicySetting,
  input  wire logic                strapSelectLow,
  input  wire logic                strapSelectLowFloat,
  input  wire logic                strapSelectHigh,
  input  wire logic                strapSelectHighFloat,
  input  wire logic [3:0]          updatePortIn,
  output logic      [3:0]          updatePortOut,
  output logic      [3:0]          updatePortOe,
  input  wire logic                spiSelectOut,
  input  wire logic                spiMisoOut,
  input  wire logic                serialDataOut,
  input  wire logic                serialClockOut,
  input  wire logic                sdaOut,
  input  wire logic                sclOut,
  output logic                     serialDataIn,
  output logic                     spiSelectIn,
  output logic                     serialClockIn,
  output logic                     sdaIn,
  output bum_pkg::bum_mode_t       modeSelected,
  output logic                     modeLatched,
  output logic                     normalBoot
);
  import bum_pkg::*;

  // ==========================================================================
  // Strap decode
  bum_mode_t strapMode;
  bum_mode_t decoded;
  logic      strapsDriven;

  always_comb begin
    strapsDriven = !strapSelectLowFloat && !strapSelectHighFloat;
  end

  always_comb begin
    strapMode = MODE_OFF;
    unique case ({strapSelectHigh, strapSelectLow})
      2'b10: begin
        strapMode = MODE_UART;
      end
      2'b01: begin
        strapMode = MODE_I2C;
      end
      2'b11: begin
        strapMode = MODE_SPI;
      end
      2'b00: begin
        strapMode = MODE_OFF;
      end
    endcase
  end

  always_comb begin
    decoded = MODE_OFF;
    if (ownerPolicySetting && strapsDriven) begin
      decoded = strapMode;
    end
  end

  // ==========================================================================
  // Latch at reset release
  logic sampled_q;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sampled_q <= 1'b0;
    end else begin
      sampled_q <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      modeSelected <= MODE_OFF;
    end else if (!sampled_q) begin
      modeSelected <= decoded;
    end
  end

  // ==========================================================================
  // Boot status
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      modeLatched <= 1'b0;
    end else begin
      modeLatched <= sampled_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      normalBoot <= 1'b0;
    end else begin
      normalBoot <= sampled_q && (modeSelected == MODE_OFF);
    end
  end

  // ==========================================================================
  // Pin drive values
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      updatePortOut <= 4'h0;
    end else begin
      updatePortOut <= 4'h0;
      unique case (modeSelected)
        MODE_I2C: begin
          updatePortOut[PIN_DIN]  <= 1'b0;
          updatePortOut[PIN_DOUT] <= 1'b0;
        end
        MODE_UART: begin
          updatePortOut[PIN_DOUT] <= serialDataOut;
        end
        MODE_SPI: begin
          updatePortOut[PIN_MISO] <= spiMisoOut;
        end
        MODE_OFF: begin
          updatePortOut <= 4'h0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      updatePortOe <= 4'h0;
    end else begin
      updatePortOe <= 4'h0;
      unique case (modeSelected)
        MODE_I2C: begin
          updatePortOe[PIN_DIN]  <= !sclOut;
          updatePortOe[PIN_DOUT] <= !sdaOut;
        end
        MODE_UART: begin
          updatePortOe[PIN_DOUT] <= 1'b1;
        end
        MODE_SPI: begin
          updatePortOe[PIN_MISO] <= !spiSelectIn;
        end
        MODE_OFF: begin
          updatePortOe <= 4'h0;
        end
      endcase
    end
  end

  // ==========================================================================
  // Routed inputs
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      serialDataIn <= DATA_IN_IDLE;
    end else begin
      unique case (modeSelected)
        MODE_I2C, MODE_UART, MODE_SPI: begin
          serialDataIn <= updatePortIn[PIN_DIN];
        end
        MODE_OFF: begin
          serialDataIn <= DATA_IN_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      spiSelectIn <= SELECT_IN_IDLE;
    end else begin
      unique case (modeSelected)
        MODE_SPI: begin
          spiSelectIn <= updatePortIn[PIN_CS];
        end
        MODE_I2C, MODE_UART, MODE_OFF: begin
          spiSelectIn <= SELECT_IN_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      serialClockIn <= CLOCK_IN_IDLE;
    end else begin
      unique case (modeSelected)
        MODE_SPI: begin
          serialClockIn <= updatePortIn[PIN_DOUT];
        end
        MODE_I2C, MODE_UART, MODE_OFF: begin
          serialClockIn <= CLOCK_IN_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sdaIn <= SDA_IN_IDLE;
    end else begin
      unique case (modeSelected)
        MODE_I2C: begin
          sdaIn <= updatePortIn[PIN_DOUT];
        end
        MODE_UART, MODE_SPI, MODE_OFF: begin
          sdaIn <= SDA_IN_IDLE;
        end
      endcase
    end
  end

endmodule

// ==== design/bum_pkg.sv ====
// Purpose: Constants and types for the boot update mode selector.
// Assumes: Strap pins report a driven level and a floating indication.
// Notes:   Mode codes are internal only.
package bum_pkg;

  // ==========================================================================
  // Mode selection
  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_I2C,
    MODE_UART,
    MODE_SPI
  } bum_mode_t;

  // ==========================================================================
  // Port pin indices
  localparam int PIN_COUNT = 4;
  localparam int PIN_CS    = 0;
  localparam int PIN_DIN   = 1;
  localparam int PIN_MISO  = 2;
  localparam int PIN_DOUT  = 3;

  // ==========================================================================
  // Idle levels of the routed inputs
  localparam logic DATA_IN_IDLE   = 1'b1;
  localparam logic SELECT_IN_IDLE = 1'b1;
  localparam logic CLOCK_IN_IDLE  = 1'b0;
  localparam logic SDA_IN_IDLE    = 1'b1;

endpackage

// ==== testbench/bum_boot_update_mode_select_tb_top.sv ====
// Purpose: Self-checking bench for the mode selector.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes:   Straps come from the host model.
`timescale 1ns/1ps
module bum_boot_update_mode_select_tb_top;
  import bum_pkg::*;
  logic sys_clk = 0, reset = 1, spiSelectOut = 1, spiMisoOut = 0, sdaOut = 1;
  logic sclOut = 1, serialClockOut = 0, serialDataOut = 1, serialDataIn;
  logic ownerPolicySetting, strapSelectLow, strapSelectLowFloat, sdaIn;
  logic strapSelectHigh, strapSelectHighFloat, spiSelectIn, serialClockIn;
  logic modeLatched, normalBoot;
  logic [3:0] updatePortIn = 4'hF, updatePortOut, updatePortOe;
  bum_mode_t modeSelected;
  int n_fail = 0, samples_checked = 0;
  logic [6:0] tbl [8] = '{7'h7C, 7'h78, 7'h74, 7'h40, 7'h51, 7'h62, 7'h73,
    7'h30};
  always #2 sys_clk = ~sys_clk;
  bum_host_model i_bum_host_model (.*);
  bum_boot_update_mode_select i_bum_boot_update_mode_select (.*);
  task automatic chk(input logic [3:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    if (n_fail == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic boot(input logic [4:0] v);
    reset = 1;
    i_bum_host_model.setStraps(v);
    repeat (3) @(posedge sys_clk);
    #1 reset = 0;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  task automatic t_modes;
    foreach (tbl[i]) begin
      boot(tbl[i][6:2]);
      chk({2'h0, modeSelected}, {2'h0, tbl[i][1:0]});
      chk({2'h0, modeLatched, normalBoot}, {3'h1, ~|tbl[i][1:0]});
      chk(updatePortOe, {tbl[i][1:0] == 2'h2, 3'h0});
    end
  endtask
  task automatic t_i2c;
    boot(5'h14);
    sdaOut = 0;
    sclOut = 1;
    updatePortIn = 4'h5;
    repeat (3) @(posedge sys_clk);
    #1 chk(updatePortOe, 4'h8);
    chk(updatePortOut, 4'h0);
    chk({spiSelectIn, serialDataIn, serialClockIn, sdaIn}, 4'h8);
    sdaOut = 1;
  endtask
  task automatic t_spi;
    boot(5'h1C);
    spiMisoOut = 1;
    updatePortIn = 4'hA;
    repeat (3) @(posedge sys_clk);
    #1 chk(updatePortOe, 4'h4);
    chk(updatePortOut, 4'h4);
    chk({spiSelectIn, serialDataIn, serialClockIn, sdaIn}, 4'h7);
  endtask
  task automatic t_uart;
    boot(5'h18);
    i_bum_host_model.setStraps(5'h1C);
    serialDataOut = 0;
    updatePortIn = 4'hD;
    repeat (3) @(posedge sys_clk);
    #1 chk({2'h0, modeSelected}, 4'h2);
    chk({updatePortOe[3], updatePortOut[3], 1'b0, serialDataIn}, 4'h8);
  endtask
  initial begin
    t_modes;
    t_uart;
    t_i2c;
    t_spi;
    complete_run;
  end
endmodule
bind bum_boot_update_mode_select bum_monitor i_bum_monitor (.*);

// ==== testbench/bum_host_model.sv ====
// Purpose: Update host that sets policy and straps.
// Assumes: Straps are set while reset is held, and once after release in t_uart.
// Notes:   A floating strap also shows a high level.
`timescale 1ns/1ps
module bum_host_model (
  output logic ownerPolicySetting,
  output logic strapSelectHigh,
  output logic strapSelectLow,
  output logic strapSelectHighFloat,
  output logic strapSelectLowFloat
);
  task automatic setStraps(input logic [4:0] v);
    {ownerPolicySetting, strapSelectHigh, strapSelectLow,
     strapSelectHighFloat, strapSelectLowFloat} = v;
  endtask
  initial setStraps(5'h00);
endmodule

// ==== testbench/bum_monitor.sv ====
// Purpose: Port assertions for the mode selector.
// Assumes: Synchronous active-high reset.
// Notes:   Bound from the bench top.
`timescale 1ns/1ps
module bum_monitor (
  input wire logic               sys_clk,
  input wire logic               reset,
  input wire logic               ownerPolicySetting,
  input wire logic               strapSelectLow,
  input wire logic               strapSelectLowFloat,
  input wire logic               strapSelectHigh,
  input wire logic               strapSelectHighFloat,
  input wire logic [3:0]         updatePortOe,
  input wire bum_pkg::bum_mode_t modeSelected,
  input wire logic               modeLatched,
  input wire logic               normalBoot
);
  import bum_pkg::*;
  bum_mode_t d;
  assign d = (ownerPolicySetting && !strapSelectLowFloat &&
    !strapSelectHighFloat) ? bum_mode_t'({strapSelectHigh, strapSelectLow})
    : MODE_OFF;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence s_rel(bum_mode_t m); $fell(reset) && d == m; endsequence
  property p_dec_off; s_rel(MODE_OFF) |=> modeSelected == MODE_OFF;
  endproperty
  property p_dec_i2c; s_rel(MODE_I2C) |=> modeSelected == MODE_I2C;
  endproperty
  property p_dec_uart; s_rel(MODE_UART) |=> modeSelected == MODE_UART;
  endproperty
  property p_dec_spi; s_rel(MODE_SPI) |=> modeSelected == MODE_SPI;
  endproperty
  property p_lat; s_rel(d) |=> ##1 modeLatched; endproperty
  property p_hold; modeLatched |=> $stable(modeSelected); endproperty
  property p_nb; modeLatched |-> normalBoot == (modeSelected == MODE_OFF);
  endproperty
  property p_tx; modeLatched && modeSelected == MODE_UART |=> updatePortOe[3];
  endproperty
  a_dec_off: assert property (p_dec_off) else $error("off");
  a_dec_i2c: assert property (p_dec_i2c) else $error("i2c");
  a_dec_uart: assert property (p_dec_uart) else $error("uart");
  a_dec_spi: assert property (p_dec_spi) else $error("spi");
  a_lat: assert property (p_lat) else $error("latch");
  a_hold: assert property (p_hold) else $error("hold");
  a_nb: assert property (p_nb) else $error("boot");
  a_tx: assert property (p_tx) else $error("tx");
endmodule
